// *** core/hac_core.sv ***
`timescale 1ns/1ps
module hac_core #(
    parameter logic [hac_pkg::ANGLE_W-1:0] MISMATCH_LIMIT = hac_pkg::DEFAULT_MISMATCH_LIMIT
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // plate samples from the front end (same clock)
    input wire logic [hac_pkg::NUM_PLATES-1:0][hac_pkg::SAMPLE_W-1:0] plate_field_sample_in,
    input wire hac_pkg::hac_temps_s temp_raw_in,
    // serial frame pins, carrier start and status clear
    input wire logic spi_sclk_in,
    input wire logic spi_cs_n_in,
    input wire logic pwm_carrier_start_in,
    input wire logic status_clear_in,
    // results
    output hac_pkg::hac_angles_s angles_out,
    output logic angle_update_out,
    output logic [hac_pkg::ANGLE_W-1:0] serial_angle_out,
    output logic [hac_pkg::ANGLE_W-1:0] pwm_angle_out,
    output hac_pkg::hac_temps_s temps_out,
    output logic safe_state_out,
    output logic [hac_pkg::STATUS_W-1:0] status_out
);

    localparam int W = hac_pkg::CORDIC_W;
    localparam int AW = hac_pkg::ANGLE_W;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // multiply by an unsigned Q0.16 gain
    function automatic logic signed [W-1:0] scale_q16(input logic signed [W-1:0] v, input logic [15:0] k);
        logic signed [W+16:0] p;
        p = v * $signed({1'b0, k});
        return p[W+15:16];
    endfunction

    // arctangent of 2^-i in angle units of a full turn
    function automatic logic [AW-1:0] atan_step(input logic [hac_pkg::ITER_W-1:0] i);
        logic [AW-1:0] r;
        r = 16'h0000;
        unique case (i)
            4'h0: r = 16'h2000;
            4'h1: r = 16'h12E4;
            4'h2: r = 16'h09FB;
            4'h3: r = 16'h0511;
            4'h4: r = 16'h028B;
            4'h5: r = 16'h0146;
            4'h6: r = 16'h00A3;
            4'h7: r = 16'h0051;
            4'h8: r = 16'h0029;
            4'h9: r = 16'h0014;
            4'hA: r = 16'h000A;
            4'hB: r = 16'h0005;
            4'hC: r = 16'h0003;
            4'hD: r = 16'h0001;
            default: r = 16'h0000;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // channel forming and engine inputs
    // ------------------------------------------------------------
    logic signed [W-1:0] ch_a;
    logic signed [W-1:0] ch_b;
    logic signed [W-1:0] ch_c;
    logic signed [W-1:0] init_x [hac_pkg::NUM_PATHS];
    logic signed [W-1:0] init_y [hac_pkg::NUM_PATHS];
    logic [AW-1:0] init_z [hac_pkg::NUM_PATHS];

    // differential channels from opposite plates
    always_comb begin
        ch_a = W'($signed(plate_field_sample_in[0])) - W'($signed(plate_field_sample_in[3]));
        ch_b = W'($signed(plate_field_sample_in[1])) - W'($signed(plate_field_sample_in[4]));
        ch_c = W'($signed(plate_field_sample_in[2])) - W'($signed(plate_field_sample_in[5]));
    end

    // vector for each path; path 0 from all three channels, paths 1-3 pair P,Q with Q 60 degrees behind P
    always_comb begin
        init_x[0] = ch_a + W'((ch_b - ch_c) / 2);
        init_y[0] = scale_q16(ch_b + ch_c, hac_pkg::GAIN_SQRT3_HALF);
        init_z[0] = 16'h0000;
        init_x[1] = ch_a;
        init_y[1] = scale_q16(W'(2 * ch_b - ch_a), hac_pkg::GAIN_INV_SQRT3);
        init_z[1] = 16'h0000;
        init_x[2] = ch_b;
        init_y[2] = scale_q16(W'(2 * ch_c - ch_b), hac_pkg::GAIN_INV_SQRT3);
        init_z[2] = hac_pkg::ANGLE_60_DEG;
        init_x[3] = ch_c;
        init_y[3] = scale_q16(W'(-2 * ch_a - ch_c), hac_pkg::GAIN_INV_SQRT3);
        init_z[3] = hac_pkg::ANGLE_120_DEG;
    end

    // ------------------------------------------------------------
    // sequencer: refresh counter and solve state
    // ------------------------------------------------------------
    hac_pkg::hac_state_e state_ff, nxt_state;
    logic [hac_pkg::CNT_W-1:0] refresh_cnt_ff, nxt_refresh_cnt;
    logic [hac_pkg::ITER_W-1:0] iter_ff, nxt_iter;
    logic start_pulse;

    // a new solve starts every refresh period regardless of any output
    always_comb begin
        nxt_refresh_cnt = refresh_cnt_ff + 6'h01;
        start_pulse = 1'b0;
        if (refresh_cnt_ff == hac_pkg::CNT_W'(hac_pkg::REFRESH_CYCLES - 1)) begin
            nxt_refresh_cnt = 6'h00;
            start_pulse = 1'b1;
        end
        nxt_state = state_ff;
        nxt_iter = iter_ff;
        unique case (state_ff)
            hac_pkg::HAC_WAIT: begin
                if (start_pulse) begin
                    nxt_state = hac_pkg::HAC_SOLVE;
                    nxt_iter = 4'h0;
                end
            end
            hac_pkg::HAC_SOLVE: begin
                nxt_iter = iter_ff + 4'h1;
                if (iter_ff == hac_pkg::LAST_ITER) begin
                    nxt_state = hac_pkg::HAC_STORE;
                end
            end
            hac_pkg::HAC_STORE: begin
                nxt_state = hac_pkg::HAC_WAIT;
            end
            default: begin
                nxt_state = hac_pkg::HAC_WAIT;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= hac_pkg::HAC_WAIT;
            refresh_cnt_ff <= 6'h00;
            iter_ff <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            refresh_cnt_ff <= nxt_refresh_cnt;
            iter_ff <= nxt_iter;
        end
    end

    // ------------------------------------------------------------
    // four vectoring engines, one per path
    // ------------------------------------------------------------
    logic [AW-1:0] angle_ff [hac_pkg::NUM_PATHS];

    for (genvar k = 0; k < hac_pkg::NUM_PATHS; k++) begin : g_path
        logic signed [W-1:0] x_ff, nxt_x;
        logic signed [W-1:0] y_ff, nxt_y;
        logic [AW-1:0] z_ff, nxt_z;
        logic [AW-1:0] nxt_angle;

        // left half-plane folded by a half turn, then shift-add rotations
        always_comb begin
            nxt_x = x_ff;
            nxt_y = y_ff;
            nxt_z = z_ff;
            nxt_angle = angle_ff[k];
            if (state_ff == hac_pkg::HAC_WAIT && start_pulse) begin
                nxt_x = init_x[k];
                nxt_y = init_y[k];
                nxt_z = init_z[k];
                if (init_x[k] < 0) begin
                    nxt_x = -init_x[k];
                    nxt_y = -init_y[k];
                    nxt_z = init_z[k] + hac_pkg::ANGLE_HALF_TURN;
                end
            end else if (state_ff == hac_pkg::HAC_SOLVE) begin
                if (y_ff >= 0) begin
                    nxt_x = x_ff + (y_ff >>> iter_ff);
                    nxt_y = y_ff - (x_ff >>> iter_ff);
                    nxt_z = z_ff + atan_step(iter_ff);
                end else begin
                    nxt_x = x_ff - (y_ff >>> iter_ff);
                    nxt_y = y_ff + (x_ff >>> iter_ff);
                    nxt_z = z_ff - atan_step(iter_ff);
                end
            end else if (state_ff == hac_pkg::HAC_STORE) begin
                nxt_angle = z_ff;
            end
        end

        // engine registers
        always_ff @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                x_ff <= '0;
                y_ff <= '0;
                z_ff <= 16'h0000;
                angle_ff[k] <= 16'h0000;
            end else begin
                x_ff <= nxt_x;
                y_ff <= nxt_y;
                z_ff <= nxt_z;
                angle_ff[k] <= nxt_angle;
            end
        end
    end

    // ------------------------------------------------------------
    // serial pin synchronisers and frame capture
    // ------------------------------------------------------------
    logic [2:0] sclk_sync_ff, nxt_sclk_sync;
    logic [2:0] cs_sync_ff, nxt_cs_sync;
    logic armed_ff, nxt_armed;
    logic [AW-1:0] serial_ff, nxt_serial;
    logic [AW-1:0] pwm_ff, nxt_pwm;

    // stage 0 feeds stage 1 only; edges are taken between stages 1 and 2
    always_comb begin
        nxt_sclk_sync = {sclk_sync_ff[1:0], spi_sclk_in};
        nxt_cs_sync = {cs_sync_ff[1:0], spi_cs_n_in};
        nxt_armed = armed_ff;
        nxt_serial = serial_ff;
        if (cs_sync_ff[2] && !cs_sync_ff[1]) begin
            nxt_armed = 1'b1;
        end
        if (cs_sync_ff[1]) begin
            nxt_armed = 1'b0;
        end else if (armed_ff && (sclk_sync_ff[2] != sclk_sync_ff[1])) begin
            nxt_serial = angle_ff[0];
            nxt_armed = 1'b0; // held for the rest of the frame
        end
        nxt_pwm = pwm_ff;
        if (pwm_carrier_start_in) begin
            nxt_pwm = angle_ff[0];
        end
    end

    // capture registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sclk_sync_ff <= 3'h0;
            cs_sync_ff <= 3'h7;
            armed_ff <= 1'b0;
            serial_ff <= 16'h0000;
            pwm_ff <= 16'h0000;
        end else begin
            sclk_sync_ff <= nxt_sclk_sync;
            cs_sync_ff <= nxt_cs_sync;
            armed_ff <= nxt_armed;
            serial_ff <= nxt_serial;
            pwm_ff <= nxt_pwm;
        end
    end

    // ------------------------------------------------------------
    // monitor: mismatch, temperature and sticky status
    // ------------------------------------------------------------
    logic safe_ff, nxt_safe;
    logic [hac_pkg::STATUS_W-1:0] status_ff, nxt_status;
    hac_pkg::hac_temps_s temps_ff, nxt_temps;
    logic mismatch;
    logic over_temp;
    logic under_temp;
    logic signed [AW-1:0] diff;
    logic [AW-1:0] diff_abs;

    // safe state latches until reset; status bits set wins over clear
    always_comb begin
        mismatch = 1'b0;
        diff = '0;
        diff_abs = '0;
        for (int p = 1; p < hac_pkg::NUM_PATHS; p++) begin
            diff = $signed(angle_ff[0] - angle_ff[p]);
            diff_abs = (diff < 0) ? AW'(-diff) : AW'(diff);
            if (diff_abs > MISMATCH_LIMIT) begin
                mismatch = 1'b1;
            end
        end
        nxt_temps = temp_raw_in;
        over_temp = (temps_ff.main_temp > hac_pkg::OVER_TEMP_COUNTS) ||
                    (temps_ff.redundant_temp > hac_pkg::OVER_TEMP_COUNTS);
        under_temp = (temps_ff.main_temp < hac_pkg::UNDER_TEMP_COUNTS) ||
                     (temps_ff.redundant_temp < hac_pkg::UNDER_TEMP_COUNTS);
        nxt_safe = safe_ff | mismatch;
        nxt_status = status_clear_in ? 3'h0 : status_ff;
        nxt_status[hac_pkg::ST_SAFE_BIT] = nxt_status[hac_pkg::ST_SAFE_BIT] | mismatch;
        nxt_status[hac_pkg::ST_OVER_BIT] = nxt_status[hac_pkg::ST_OVER_BIT] | over_temp;
        nxt_status[hac_pkg::ST_UNDER_BIT] = nxt_status[hac_pkg::ST_UNDER_BIT] | under_temp;
    end

    // monitor registers
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            safe_ff <= 1'b0;
            status_ff <= 3'h0;
            temps_ff <= '0;
        end else begin
            safe_ff <= nxt_safe;
            status_ff <= nxt_status;
            temps_ff <= nxt_temps;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------
    logic update_ff;

    // one-cycle mark, high in the first cycle that shows the new angles
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            update_ff <= 1'b0;
        end else begin
            update_ff <= (state_ff == hac_pkg::HAC_STORE);
        end
    end

    assign angles_out = {angle_ff[0], angle_ff[1], angle_ff[2], angle_ff[3]};
    assign angle_update_out = update_ff;
    assign serial_angle_out = serial_ff;
    assign pwm_angle_out = pwm_ff;
    assign temps_out = temps_ff;
    assign safe_state_out = safe_ff;
    assign status_out = status_ff;

endmodule // hac_core

// *** include/hac_pkg.sv ***
package hac_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int ANGLE_W = 16;
    localparam int TEMP_W = 12;
    localparam int CORDIC_W = 20;
    localparam int ITER_W = 4;
    localparam int NUM_PLATES = 6;
    localparam int NUM_PATHS = 4;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int ANGLE_REFRESH_PERIOD_NS = 2000;
    localparam int REFRESH_CYCLES = ANGLE_REFRESH_PERIOD_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 6;
    localparam logic [ITER_W-1:0] LAST_ITER = 4'hD;

    // ------------------------------------------------------------
    // arithmetic constants (unsigned Q0.16 gains, angles per full turn)
    // ------------------------------------------------------------
    localparam logic [15:0] GAIN_SQRT3_HALF = 16'hDDB4;
    localparam logic [15:0] GAIN_INV_SQRT3 = 16'h93CD;
    localparam logic [ANGLE_W-1:0] ANGLE_HALF_TURN = 16'h8000;
    localparam logic [ANGLE_W-1:0] ANGLE_60_DEG = 16'h2AAB;
    localparam logic [ANGLE_W-1:0] ANGLE_120_DEG = 16'h5555;
    localparam logic [ANGLE_W-1:0] DEFAULT_MISMATCH_LIMIT = 16'h0100;

    // ------------------------------------------------------------
    // temperature scaling and thresholds
    // ------------------------------------------------------------
    localparam int TEMP_COUNTS_PER_DEG = 8;
    localparam int OVER_TEMP_DEG = 170;
    localparam int UNDER_TEMP_DEG = -60;
    localparam logic signed [TEMP_W-1:0] OVER_TEMP_COUNTS = TEMP_W'(OVER_TEMP_DEG * TEMP_COUNTS_PER_DEG);
    localparam logic signed [TEMP_W-1:0] UNDER_TEMP_COUNTS = TEMP_W'(UNDER_TEMP_DEG * TEMP_COUNTS_PER_DEG);

    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int ST_SAFE_BIT = 0;
    localparam int ST_OVER_BIT = 1;
    localparam int ST_UNDER_BIT = 2;
    localparam int STATUS_W = 3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HAC_WAIT = 3'h1,
        HAC_SOLVE = 3'h2,
        HAC_STORE = 3'h4
    } hac_state_e;

    typedef struct packed {
        logic [ANGLE_W-1:0] main_angle;
        logic [ANGLE_W-1:0] redundant_angle_ab;
        logic [ANGLE_W-1:0] redundant_angle_bc;
        logic [ANGLE_W-1:0] redundant_angle_ca;
    } hac_angles_s;

    typedef struct packed {
        logic signed [TEMP_W-1:0] main_temp;
        logic signed [TEMP_W-1:0] redundant_temp;
    } hac_temps_s;

endpackage

// *** tb/hac_core_bench.sv ***
`timescale 1ns/1ps
module hac_core_bench;
    // -----------------------------------------
    // signals
    // -----------------------------------------
    logic clk_in;
    logic rst_n_in;
    logic [15:0] angle_code;
    logic [15:0] common_field;
    logic [15:0] plate_fault;
    logic [hac_pkg::NUM_PLATES-1:0][hac_pkg::SAMPLE_W-1:0] plates;
    hac_pkg::hac_temps_s temp_raw;
    logic sclk;
    logic cs_n;
    logic pwm_start;
    logic status_clear;
    hac_pkg::hac_angles_s angles;
    logic angle_update;
    logic [15:0] serial_angle;
    logic [15:0] pwm_angle;
    hac_pkg::hac_temps_s temps;
    logic safe_state;
    logic [hac_pkg::STATUS_W-1:0] status;
    int fails;
    int check_count;
    int cycles;

    hac_front_end u_hac_front_end (.clk_in(clk_in), .angle_code_in(angle_code), .common_in(common_field),
        .fault_in(plate_fault), .plate_field_sample_out(plates));

    hac_core u_hac_core (.clk_in(clk_in), .rst_n_in(rst_n_in), .plate_field_sample_in(plates),
        .temp_raw_in(temp_raw), .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .pwm_carrier_start_in(pwm_start),
        .status_clear_in(status_clear), .angles_out(angles), .angle_update_out(angle_update),
        .serial_angle_out(serial_angle), .pwm_angle_out(pwm_angle), .temps_out(temps),
        .safe_state_out(safe_state), .status_out(status));

    // -----------------------------------------
    // helpers
    // -----------------------------------------
    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            fails++;
            $display("BAD t=%0t %s", $time, msg);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #5;
    endtask

    // wrapped distance between two full-turn angles
    function automatic bit near(input logic [15:0] a, input logic [15:0] b, input int tol);
        logic [15:0] d;
        d = a - b;
        return (d <= tol) || (d >= 65536 - tol);
    endfunction

    task automatic wait_update;
        int n;
        n = 0;
        while (angle_update !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check(n < 100, "no angle update");
        tick(1);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // -----------------------------------------
    // scenarios
    // -----------------------------------------
    task automatic t_sweep;
        int n;
        for (int k = 0; k < 8; k++) begin
            angle_code = 16'(k * 16'h2000 + 16'h0123);
            wait_update();
            wait_update();
            check(near(angles.main_angle, angle_code, 4), "main angle");
            check(near(angles.redundant_angle_ab, angle_code, 8), "angle ab");
            check(near(angles.redundant_angle_bc, angle_code, 8), "angle bc");
            check(near(angles.redundant_angle_ca, angle_code, 8), "angle ca");
            check(safe_state === 1'b0, "safe state without mismatch");
        end
        n = 1;
        while (angle_update !== 1'b1 && n < 100) begin
            tick(1);
            n++;
        end
        check(n == 40, "refresh period");
        $display("test sweep done");
    endtask

    task automatic t_pwm;
        logic [15:0] held;
        angle_code = 16'h3210;
        wait_update();
        wait_update();
        pwm_start = 1'b1;
        tick(1);
        pwm_start = 1'b0;
        held = angles.main_angle;
        check(pwm_angle === held, "pwm capture");
        check(near(pwm_angle, 16'h3210, 4), "pwm angle value");
        angle_code = 16'hB000;
        wait_update();
        wait_update();
        check(pwm_angle === held, "pwm held between carriers");
        $display("test pwm done");
    endtask

    task automatic t_serial;
        logic [15:0] held;
        cs_n = 1'b0;
        tick(4);
        sclk = 1'b1;
        tick(6);
        held = angles.main_angle;
        check(serial_angle === held, "serial capture");
        check(near(serial_angle, 16'hB000, 4), "serial angle value");
        angle_code = 16'h5000;
        wait_update();
        sclk = 1'b0;
        wait_update();
        sclk = 1'b1;
        tick(6);
        check(serial_angle === held, "serial held in frame");
        cs_n = 1'b1;
        sclk = 1'b0;
        tick(4);
        $display("test serial done");
    endtask

    task automatic t_temp;
        logic [11:0] tv [4] = '{12'h550, 12'h551, 12'hE20, 12'hE1F}; // 1360, 1361, -480, -481 counts
        for (int k = 0; k < 4; k++) begin
            temp_raw = {tv[k], tv[k]};
            tick(3);
            check(temps === {tv[k], tv[k]}, "temperature words");
            check(status[1] === (k == 1), "over flag");
            check(status[2] === (k == 3), "under flag");
            temp_raw = '0;
            status_clear = 1'b1;
            tick(2);
            status_clear = 1'b0;
            tick(1);
            check(status[2:1] === 2'h0, "flags cleared");
        end
        $display("test temp done");
    endtask

    task automatic t_fault;
        angle_code = 16'h4000;
        plate_fault = 16'h1000;
        wait_update();
        wait_update();
        check(safe_state === 1'b1, "mismatch safe state");
        check(status[0] === 1'b1, "mismatch status");
        plate_fault = 16'h0000;
        wait_update();
        wait_update();
        check(safe_state === 1'b1, "safe state latched");
        rst_n_in = 1'b0;
        tick(2);
        rst_n_in = 1'b1;
        tick(1);
        check(safe_state === 1'b0 && status === '0 && angles === '0, "second reset");
        $display("test fault done");
    endtask

    // -----------------------------------------
    // clock, watchdog and main sequence
    // -----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        rst_n_in = 1'b0;
        angle_code = 16'h0000;
        common_field = 16'h0BB8;
        plate_fault = 16'h0000;
        temp_raw = '0;
        sclk = 1'b0;
        cs_n = 1'b1;
        pwm_start = 1'b0;
        status_clear = 1'b0;
        tick(6);
        rst_n_in = 1'b1;
        check(angles === '0 && status === '0 && safe_state === 1'b0, "reset values");
        t_sweep();
        t_pwm();
        t_serial();
        t_temp();
        t_fault();
        summarize();
    end
endmodule // hac_core_bench

bind hac_core hac_core_checker #(.MISMATCH_LIMIT(MISMATCH_LIMIT)) u_hac_core_checker (.clk_in(clk_in),
    .rst_n_in(rst_n_in), .temp_raw_in(temp_raw_in), .spi_cs_n_in(spi_cs_n_in),
    .pwm_carrier_start_in(pwm_carrier_start_in), .angles_out(angles_out), .angle_update_out(angle_update_out),
    .serial_angle_out(serial_angle_out), .pwm_angle_out(pwm_angle_out), .temps_out(temps_out),
    .safe_state_out(safe_state_out), .status_out(status_out));

// *** tb/hac_core_checker.sv ***
`timescale 1ns/1ps
module hac_core_checker #(
    parameter logic [hac_pkg::ANGLE_W-1:0] MISMATCH_LIMIT = hac_pkg::DEFAULT_MISMATCH_LIMIT
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // watched inputs
    input wire hac_pkg::hac_temps_s temp_raw_in,
    input wire logic spi_cs_n_in,
    input wire logic pwm_carrier_start_in,
    // watched outputs
    input wire hac_pkg::hac_angles_s angles_out,
    input wire logic angle_update_out,
    input wire logic [hac_pkg::ANGLE_W-1:0] serial_angle_out,
    input wire logic [hac_pkg::ANGLE_W-1:0] pwm_angle_out,
    input wire hac_pkg::hac_temps_s temps_out,
    input wire logic safe_state_out,
    input wire logic [hac_pkg::STATUS_W-1:0] status_out
);
    // -----------------------------------------
    // mismatch between main and one redundant angle, wrapped
    // -----------------------------------------
    function automatic logic far(input logic [15:0] a, input logic [15:0] b);
        int d;
        d = int'($signed(16'(a - b)));
        return (d > int'(MISMATCH_LIMIT)) || (d < -int'(MISMATCH_LIMIT));
    endfunction

    logic mism;
    // any of the three pairs out of step
    assign mism = far(angles_out.main_angle, angles_out.redundant_angle_ab)
        || far(angles_out.main_angle, angles_out.redundant_angle_bc)
        || far(angles_out.main_angle, angles_out.redundant_angle_ca);

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // -----------------------------------------
    // assertions
    // -----------------------------------------
    update_period_a: assert property (angle_update_out |-> ##40 angle_update_out)
        else $error("angle update not every 40 cycles");
    update_gap_a: assert property (angle_update_out |=> !angle_update_out [*8])
        else $error("angle update pulse too long");
    angle_change_a: assert property (angles_out != $past(angles_out) |-> angle_update_out)
        else $error("angles changed without update pulse");
    pwm_capture_a: assert property (pwm_carrier_start_in |=> pwm_angle_out == $past(angles_out.main_angle))
        else $error("pulse width angle not captured at carrier start");
    pwm_hold_a: assert property (!pwm_carrier_start_in |=> $stable(pwm_angle_out))
        else $error("pulse width angle moved between carriers");
    serial_hold_a: assert property (spi_cs_n_in [*5] |=> $stable(serial_angle_out))
        else $error("serial angle moved outside a frame");
    safe_sticky_a: assert property (safe_state_out |=> safe_state_out)
        else $error("safe state left without reset");
    mismatch_safe_a: assert property (mism |=> safe_state_out && status_out[hac_pkg::ST_SAFE_BIT])
        else $error("angle mismatch did not enter safe state");
    no_false_safe_a: assert property (!mism && !safe_state_out |=> !safe_state_out)
        else $error("safe state without mismatch");
    over_temp_a: assert property (temps_out.main_temp > hac_pkg::OVER_TEMP_COUNTS |=> status_out[1])
        else $error("over temperature not flagged");
    under_temp_a: assert property (temps_out.main_temp < hac_pkg::UNDER_TEMP_COUNTS |=> status_out[2])
        else $error("under temperature not flagged");
    temp_copy_a: assert property ($past(rst_n_in) |-> temps_out == $past(temp_raw_in))
        else $error("temperature words not copied");

    // main scenarios reached
    cover property (angle_update_out);
    cover property ($rose(safe_state_out));
    cover property (pwm_carrier_start_in);
    cover property ($rose(status_out[1]));
endmodule // hac_core_checker

// *** tb/hac_front_end.sv ***
`timescale 1ns/1ps
module hac_front_end (
    // clock
    input wire logic clk_in,
    // magnet angle, common stray field, offset on plate 0
    input wire logic [15:0] angle_code_in,
    input wire logic [15:0] common_in,
    input wire logic [15:0] fault_in,
    // converted plate samples
    output logic [hac_pkg::NUM_PLATES-1:0][hac_pkg::SAMPLE_W-1:0] plate_field_sample_out
);
    // normal field on a ring of six plates, 60 degrees apart
    function automatic logic [15:0] plate_value(input int idx);
        real ph;
        ph = 6.283185307 * angle_code_in / 65536.0 - idx * 1.047197551;
        return 16'($rtoi(8000.0 * $cos(ph))) + common_in + ((idx == 0) ? fault_in : 16'h0000);
    endfunction

    // converter output, one fresh set each clock
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < hac_pkg::NUM_PLATES; i++) begin
            plate_field_sample_out[i] <= plate_value(i);
        end
    end
endmodule // hac_front_end
